// file: core/sarseq_core.sv
// sar converter sequencer with axi4-lite register file
// Summary of operation
// R1 - any reset clears control registers and sets all pins analog, switches converter off, aborts conversion
// R2 - completion loads result pair, clears start/done bit, sets completion flag
// R3 - result pair is not reset; contents survive every reset but power-up
// R4 - nonzero acquisition field gives 2 to 20 tad sampling, then conversion
// R5 - acquisition field zero: start stops sampling at once and converts after one instruction cycle
// R6 - acquisition field resets to zero, manual acquisition
// R7 - after every conversion sampling of the selected channel resumes
// R8 - no status separates acquisition from conversion; only start/done shows
// R9 - each conversion lasts exactly 13 conversion clock periods; in manual mode the first period runs short unless the divider is 2 or 4
// R10 - conversion clock is oscillator over 2,4,8,16,32,64 or internal rc
// R11 - converting continues in sleep when the internal rc clock is chosen
// R12 - software waits two tad after completion before next acquisition
// R13 - reference is software choice: supply rails or external reference pins
// R14 - result built by successive approximation, one bit per tad
// R15 - in manual mode software waits acquisition time before starting
// R16 - every shared pin individually set analog input or digital
// R17 - software configures, enables, starts, polls or waits, reads result
// R18 - software picks shortest tad above the minimum period
// R19 - manual mode start is delayed one instruction cycle before converting
// R20 - start while switched off is ignored and flag stays unchanged
module sarseq_core #(
  parameter int unsigned RES_BITS = 12,
  parameter int unsigned N_PINS = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_clk_async,
  input wire logic sleep_mode,
  input wire logic comp_above,
  output sarseq_pkg::sarseq_analog_s analog_ctrl,
  output logic [N_PINS-1:0] analog_pin_en,
  output logic conversion_complete_flag
);

  localparam logic [4:0] LAST_STEP = 5'(sarseq_pkg::CONV_TAD - 1);
  localparam logic [2:0] INSTR_LAST = 3'(sarseq_pkg::INSTR_CYCLES - 1);

  sarseq_pkg::sarseq_state_e state_reg;
  sarseq_pkg::sarseq_ctrl2_s ctrl2_reg;
  logic on_reg;
  logic [3:0] channel_reg;
  logic vpos_reg;
  logic vneg_reg;
  logic [N_PINS-1:0] pin_reg;
  logic flag_reg;
  logic [RES_BITS-1:0] result_reg;
  logic [RES_BITS-1:0] trial_reg;
  logic [4:0] step_reg;
  logic [4:0] acq_cnt_reg;
  logic [2:0] dly_cnt_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic wr_fire;
  logic wr_ctrl0;
  logic start_req;
  logic abort_req;
  logic restart;
  logic tad_tick;
  logic busy;
  logic conv_done;
  logic [31:0] rd_word;
  logic rd_mapped;
  logic [RES_BITS-1:0] trial_next;
  logic [3:0] bit_idx;

  // ---------------- axi4-lite write channel ----------------
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  // address and data latch independently, write fires when both are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  // write response, slverr for an unmapped word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= sarseq_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      case ({awaddr_reg[7:2], 2'b00})
        sarseq_pkg::OFF_CTRL0, sarseq_pkg::OFF_PINREF, sarseq_pkg::OFF_CTRL2,
        sarseq_pkg::OFF_RES_HI, sarseq_pkg::OFF_RES_LO, sarseq_pkg::OFF_STATUS:
          bresp_reg <= sarseq_pkg::RESP_OKAY;
        default: bresp_reg <= sarseq_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ---------------- control register decode ----------------
  assign wr_ctrl0 = wr_fire && wstrb_reg[0] && ({awaddr_reg[7:2], 2'b00} == sarseq_pkg::OFF_CTRL0);
  assign busy = (state_reg == sarseq_pkg::ST_ACQ) || (state_reg == sarseq_pkg::ST_DELAY) ||
                (state_reg == sarseq_pkg::ST_CONV);
  // start only when the module is, and stays, switched on
  assign start_req = wr_ctrl0 && wdata_reg[sarseq_pkg::CTRL0_GO_BIT] &&
                     wdata_reg[sarseq_pkg::CTRL0_ON_BIT] && on_reg &&
                     (state_reg == sarseq_pkg::ST_SAMPLE); // R20
  // clearing the start bit or switching off while busy abandons the conversion
  assign abort_req = wr_ctrl0 && busy && (!wdata_reg[sarseq_pkg::CTRL0_GO_BIT] ||
                     !wdata_reg[sarseq_pkg::CTRL0_ON_BIT]);
  assign restart = start_req;

  // module enable, channel, reference and pin configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      on_reg <= 1'b0; // R1
      channel_reg <= sarseq_pkg::RST_CHANNEL;
      vpos_reg <= 1'b0;
      vneg_reg <= 1'b0;
      pin_reg <= N_PINS'(sarseq_pkg::RST_PIN_ANALOG);
      ctrl2_reg.acq <= sarseq_pkg::RST_ACQ; // R6
      ctrl2_reg.clksel <= sarseq_pkg::RST_CLKSEL;
    end
    else if (wr_fire)
    begin
      if (wr_ctrl0)
      begin
        on_reg <= wdata_reg[sarseq_pkg::CTRL0_ON_BIT];
        channel_reg <= wdata_reg[sarseq_pkg::CTRL0_CH_LSB +: 4];
      end
      if ({awaddr_reg[7:2], 2'b00} == sarseq_pkg::OFF_PINREF)
      begin
        if (wstrb_reg[0])
        begin
          vpos_reg <= wdata_reg[sarseq_pkg::PINREF_VPOS_BIT]; // R13
          vneg_reg <= wdata_reg[sarseq_pkg::PINREF_VNEG_BIT]; // R13
        end
        if (wstrb_reg[2] && wstrb_reg[3])
          pin_reg <= wdata_reg[sarseq_pkg::PINREF_PIN_LSB +: N_PINS]; // R16
      end
      if (wstrb_reg[0] && ({awaddr_reg[7:2], 2'b00} == sarseq_pkg::OFF_CTRL2))
      begin
        ctrl2_reg.acq <= wdata_reg[sarseq_pkg::CTRL2_ACQ_LSB +: 3]; // R4
        ctrl2_reg.clksel <= wdata_reg[sarseq_pkg::CTRL2_CLK_LSB +: 3]; // R10
      end
    end
  end

  // ---------------- conversion clock ----------------
  sarseq_tad_gen u_tad_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(ctrl2_reg.clksel),
    .rc_clk_async(rc_clk_async),
    .sleep_mode(sleep_mode),
    .restart(restart),
    .tad_tick(tad_tick)
  );

  // ---------------- sequencer ----------------
  assign conv_done = (state_reg == sarseq_pkg::ST_CONV) && tad_tick &&
                     (step_reg == LAST_STEP); // R9

  // off, sampling, programmed acquisition, manual delay, conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= sarseq_pkg::ST_OFF; // R1
    else if (abort_req || (wr_ctrl0 && !wdata_reg[sarseq_pkg::CTRL0_ON_BIT]))
      state_reg <= wdata_reg[sarseq_pkg::CTRL0_ON_BIT] ? sarseq_pkg::ST_SAMPLE :
                   sarseq_pkg::ST_OFF;
    else
    begin
      unique case (state_reg)
        sarseq_pkg::ST_OFF:
          if (wr_ctrl0 && wdata_reg[sarseq_pkg::CTRL0_ON_BIT])
            state_reg <= sarseq_pkg::ST_SAMPLE;
        sarseq_pkg::ST_SAMPLE:
          if (start_req)
            state_reg <= (ctrl2_reg.acq == 3'h0) ? sarseq_pkg::ST_DELAY : // R5
                         sarseq_pkg::ST_ACQ; // R4
        sarseq_pkg::ST_ACQ:
          if (tad_tick && (acq_cnt_reg == sarseq_pkg::acq_tad(ctrl2_reg.acq) - 5'h01))
            state_reg <= sarseq_pkg::ST_CONV; // R4
        sarseq_pkg::ST_DELAY:
          if (dly_cnt_reg == INSTR_LAST)
            state_reg <= sarseq_pkg::ST_CONV; // R19
        sarseq_pkg::ST_CONV:
          if (conv_done)
            state_reg <= sarseq_pkg::ST_SAMPLE; // R7
      endcase
    end
  end

  // acquisition and instruction-cycle counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_reg == sarseq_pkg::ST_SAMPLE)
    begin
      acq_cnt_reg <= 5'h00;
      dly_cnt_reg <= 3'h0;
    end
    else
    begin
      if (state_reg == sarseq_pkg::ST_ACQ && tad_tick)
        acq_cnt_reg <= acq_cnt_reg + 5'h01; // R4
      if (state_reg == sarseq_pkg::ST_DELAY)
        dly_cnt_reg <= dly_cnt_reg + 3'h1; // R19
    end
  end

  // successive approximation trial word
  assign bit_idx = 4'(RES_BITS - 1) - step_reg[3:0];
  always_comb
  begin
    trial_next = trial_reg;
    if (!comp_above)
      trial_next[bit_idx] = 1'b0; // R14
    if (bit_idx != 4'h0)
      trial_next[bit_idx - 4'h1] = 1'b1; // R14
  end

  // step counter and trial register, one decision per tad
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_reg != sarseq_pkg::ST_CONV)
    begin
      step_reg <= 5'h00;
      trial_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
    end
    else if (tad_tick)
    begin
      step_reg <= step_reg + 5'h01; // R9
      if (step_reg < 5'(RES_BITS))
        trial_reg <= trial_next; // R14
    end
  end

  // result pair has no reset and is only loaded at completion
  always_ff @(posedge aclk)
  begin
    if (conv_done)
      result_reg <= trial_reg; // R2 R3
  end

  // completion flag, a completion beats a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_reg <= 1'b0; // R1
    else if (conv_done)
      flag_reg <= 1'b1; // R2
    else if (wr_fire && wstrb_reg[0] && wdata_reg[sarseq_pkg::STATUS_FLAG_BIT] &&
             ({awaddr_reg[7:2], 2'b00} == sarseq_pkg::OFF_STATUS))
      flag_reg <= 1'b0;
  end

  // ---------------- axi4-lite read channel ----------------
  assign s_axi_arready = !rvalid_reg;

  // read mux; start/done reads as busy, no acquisition/conversion split
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      sarseq_pkg::OFF_CTRL0:
      begin
        rd_word[sarseq_pkg::CTRL0_ON_BIT] = on_reg;
        rd_word[sarseq_pkg::CTRL0_GO_BIT] = busy; // R2 R8
        rd_word[sarseq_pkg::CTRL0_CH_LSB +: 4] = channel_reg;
      end
      sarseq_pkg::OFF_PINREF:
      begin
        rd_word[sarseq_pkg::PINREF_VPOS_BIT] = vpos_reg;
        rd_word[sarseq_pkg::PINREF_VNEG_BIT] = vneg_reg;
        rd_word[sarseq_pkg::PINREF_PIN_LSB +: N_PINS] = pin_reg;
      end
      sarseq_pkg::OFF_CTRL2:
      begin
        rd_word[sarseq_pkg::CTRL2_ACQ_LSB +: 3] = ctrl2_reg.acq;
        rd_word[sarseq_pkg::CTRL2_CLK_LSB +: 3] = ctrl2_reg.clksel;
      end
      sarseq_pkg::OFF_RES_HI: rd_word[RES_BITS-9:0] = result_reg[RES_BITS-1:8];
      sarseq_pkg::OFF_RES_LO: rd_word[7:0] = result_reg[7:0];
      sarseq_pkg::OFF_STATUS: rd_word[sarseq_pkg::STATUS_FLAG_BIT] = flag_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // read data register, answered one cycle after address acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sarseq_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? sarseq_pkg::RESP_OKAY : sarseq_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ---------------- analog side ----------------
  always_comb
  begin
    analog_ctrl.module_on = on_reg;
    analog_ctrl.sample_en = (state_reg == sarseq_pkg::ST_SAMPLE) ||
                            (state_reg == sarseq_pkg::ST_ACQ); // R5 R7
    analog_ctrl.channel = channel_reg;
    analog_ctrl.vref_pos_ext = vpos_reg; // R13
    analog_ctrl.vref_neg_ext = vneg_reg; // R13
    analog_ctrl.dac_code = trial_reg;
  end

  assign analog_pin_en = pin_reg; // R16
  assign conversion_complete_flag = flag_reg;

endmodule : sarseq_core

// file: core/sarseq_pkg.sv
// shared constants, types and helpers for the sar converter sequencer
package sarseq_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_PINREF = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_RES_HI = 8'h0C;
  localparam logic [7:0] OFF_RES_LO = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // field positions
  localparam int unsigned CTRL0_ON_BIT = 0;
  localparam int unsigned CTRL0_GO_BIT = 1;
  localparam int unsigned CTRL0_CH_LSB = 2;
  localparam int unsigned PINREF_VPOS_BIT = 0;
  localparam int unsigned PINREF_VNEG_BIT = 1;
  localparam int unsigned PINREF_PIN_LSB = 16;
  localparam int unsigned CTRL2_CLK_LSB = 0;
  localparam int unsigned CTRL2_ACQ_LSB = 3;
  localparam int unsigned STATUS_FLAG_BIT = 0;

  // values after reset
  localparam logic [3:0] RST_CHANNEL = 4'h0;
  localparam logic [2:0] RST_ACQ = 3'h0;
  localparam logic [2:0] RST_CLKSEL = 3'h0;
  localparam logic [11:0] RST_PIN_ANALOG = 12'hFFF;

  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned INSTR_OSCILLATOR_PERIOD = 4;
  localparam int unsigned INSTR_CYCLES = INSTR_OSCILLATOR_PERIOD;
  localparam int unsigned CONV_TAD = 13;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_ACQ, ST_DELAY, ST_CONV} sarseq_state_e;

  typedef struct packed {
    logic [2:0] acq;
    logic [2:0] clksel;
  } sarseq_ctrl2_s;

  typedef struct packed {
    logic module_on;
    logic sample_en;
    logic [3:0] channel;
    logic vref_pos_ext;
    logic vref_neg_ext;
    logic [11:0] dac_code;
  } sarseq_analog_s;

  // acquisition length in conversion clock periods
  function automatic logic [4:0] acq_tad(input logic [2:0] code);
    case (code)
      3'h0: acq_tad = 5'h00;
      3'h1: acq_tad = 5'h02;
      3'h2: acq_tad = 5'h04;
      3'h3: acq_tad = 5'h06;
      3'h4: acq_tad = 5'h08;
      3'h5: acq_tad = 5'h0C;
      3'h6: acq_tad = 5'h10;
      default: acq_tad = 5'h14;
    endcase
  endfunction : acq_tad

  // oscillator divide ratio, zero means internal rc
  function automatic logic [6:0] clk_div(input logic [2:0] sel);
    case (sel)
      3'h0: clk_div = 7'h02;
      3'h4: clk_div = 7'h04;
      3'h1: clk_div = 7'h08;
      3'h5: clk_div = 7'h10;
      3'h2: clk_div = 7'h20;
      3'h6: clk_div = 7'h40;
      default: clk_div = 7'h00;
    endcase
  endfunction : clk_div

endpackage : sarseq_pkg

// file: core/sarseq_tad_gen.sv
// conversion clock tick generator: oscillator divider or synchronised rc
module sarseq_tad_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] clk_sel,
  input wire logic rc_clk_async,
  input wire logic sleep_mode,
  input wire logic restart,
  output logic tad_tick
);

  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic [6:0] div_cnt_reg;
  logic [6:0] ratio;
  logic rc_sel;
  logic osc_tick;
  logic rc_tick;

  assign ratio = sarseq_pkg::clk_div(clk_sel);
  assign rc_sel = (ratio == 7'h00);

  // two-flop synchroniser plus edge history for the rc oscillator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end
    else
    begin
      rc_s1_reg <= rc_clk_async;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  assign rc_tick = rc_s2_reg && !rc_s3_reg;

  // oscillator divider, realigned on every restart
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart || rc_sel)
      div_cnt_reg <= 7'h00;
    else if (div_cnt_reg == ratio - 7'h01)
      div_cnt_reg <= 7'h00;
    else
      div_cnt_reg <= div_cnt_reg + 7'h01;
  end

  assign osc_tick = !rc_sel && !restart && (div_cnt_reg == ratio - 7'h01);

  // oscillator stops in sleep, only the rc source keeps running
  always_comb
  begin
    if (rc_sel)
      tad_tick = rc_tick && !restart; // R11
    else
      tad_tick = osc_tick && !sleep_mode; // R11
  end

endmodule : sarseq_tad_gen

// file: bench/sarseq_analog_model.sv
// sample-and-hold and comparator model on the converter's analog side
module sarseq_analog_model (
  input wire logic aclk,
  input wire sarseq_pkg::sarseq_analog_s analog_ctrl,
  input wire logic [11:0] level,
  output logic comp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held_reg;
  // track the input while sampling, freeze it once sampling stops
  always_ff @(posedge aclk)
    if (analog_ctrl.sample_en)
      held_reg <= level;
  // comparator against the trial code, silent while powered down
  assign comp_above = analog_ctrl.module_on && (held_reg >= analog_ctrl.dac_code);
endmodule : sarseq_analog_model

// file: bench/sarseq_core_asserts.sv
// timing checks on the sequencer's bus and analog-side ports
module sarseq_core_asserts #(
  parameter int unsigned N_PINS = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sarseq_pkg::sarseq_analog_s analog_ctrl,
  input wire logic [N_PINS-1:0] analog_pin_en,
  input wire logic conversion_complete_flag
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // responses stand until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=> !analog_ctrl.module_on
    && !conversion_complete_flag && analog_pin_en == {N_PINS{1'b1}} && !s_axi_bvalid)
    else $error("reset state wrong");
  a_flag_done: assert property ($rose(conversion_complete_flag)
    |-> $rose(analog_ctrl.sample_en)) else $error("flag without resampling");
  a_flag_off: assert property (!analog_ctrl.module_on
    |-> !$rose(conversion_complete_flag)) else $error("flag while off");
  a_dac_step: assert property (!analog_ctrl.sample_en && $changed(analog_ctrl.dac_code)
    |=> $stable(analog_ctrl.dac_code)) else $error("trial code moved twice");
endmodule : sarseq_core_asserts

bind sarseq_core sarseq_core_asserts #(.N_PINS(N_PINS)) u_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_ctrl(analog_ctrl),
  .analog_pin_en(analog_pin_en), .conversion_complete_flag(conversion_complete_flag)
);

// file: bench/tb_sarseq_core.sv
// self-checking bench for the sar converter sequencer
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("BAD %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_sarseq_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rc_clk_async = 1'b0;
  logic sleep_mode = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comp_above;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [11:0] analog_pin_en, last;
  logic [11:0] level = 12'h000;
  logic conversion_complete_flag;
  sarseq_pkg::sarseq_analog_s analog_ctrl;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int acq_n[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int div_n[6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0] clk_code[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

  always #25 aclk = ~aclk;
  // free-running rc oscillator, 4 aclk periods, phase unrelated to aclk
  initial #37 forever #100 rc_clk_async = ~rc_clk_async;

  sarseq_core DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rc_clk_async(rc_clk_async),
    .sleep_mode(sleep_mode), .comp_above(comp_above), .analog_ctrl(analog_ctrl),
    .analog_pin_en(analog_pin_en), .conversion_complete_flag(conversion_complete_flag)
  );
  sarseq_analog_model u_analog (
    .aclk(aclk), .analog_ctrl(analog_ctrl), .level(level), .comp_above(comp_above)
  );

  task automatic results();
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // write: ready looked at mid-cycle, valids released after the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!tb);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    while (!tb);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    `CHK("bresp", sarseq_pkg::RESP_OKAY, rsp)
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rsp);
    `CHK(nm, e, rd)
  endtask : rd_chk

  // one full conversion: configure, settle, start, time it, read back
  task automatic convert(input logic [2:0] clk, input logic [2:0] acq, input int div,
    input int acqn, input logic [11:0] lvl, input logic [3:0] ch);
    int n;
    int tf;
    int lo;
    level <= lvl;
    wr(sarseq_pkg::OFF_CTRL2, {26'h0, acq, clk});
    wr(sarseq_pkg::OFF_CTRL0, {26'h0, ch, 2'b01});
    repeat (200) @(posedge aclk);
    wr(sarseq_pkg::OFF_CTRL0, {26'h0, ch, 2'b11});
    n = 0;
    tf = -1;
    while (conversion_complete_flag !== 1'b1 && n < 3000)
    begin
      @(negedge aclk);
      n++;
      if (tf < 0 && analog_ctrl.sample_en === 1'b0) tf = n;
    end
    // rc ticks keep their own phase, so the first one may land up to 3 cycles early
    lo = acqn * div - ((clk == 3'h3) ? 3 : 0);
    if (acqn == 0)
    begin
      `CHK("sample stop", 1, tf)
      `CHK("manual time", 1'b1, n >= 13 * div + 2 && n <= 14 * div + 6)
    end
    else
    begin
      `CHK("acq time", 1'b1, tf >= lo && tf <= acqn * div)
      `CHK("conv time", 13 * div, n - tf)
    end
    rd_chk("result high", sarseq_pkg::OFF_RES_HI, {28'h0, lvl[11:8]});
    rd_chk("result low", sarseq_pkg::OFF_RES_LO, {24'h0, lvl[7:0]});
    rd_chk("start bit", sarseq_pkg::OFF_CTRL0, {26'h0, ch, 2'b01});
    rd_chk("flag", sarseq_pkg::OFF_STATUS, 32'h0000_0001);
    `CHK("resample", 1'b1, analog_ctrl.sample_en)
    `CHK("channel", ch, analog_ctrl.channel)
    wr(sarseq_pkg::OFF_STATUS, 32'h0000_0001);
    `CHK("flag clear", 1'b0, conversion_complete_flag)
    last = lvl;
  endtask : convert

  // cycle ceiling against a hung handshake
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("ctrl0 reset", sarseq_pkg::OFF_CTRL0, 32'h0000_0000);
    rd_chk("pins reset", sarseq_pkg::OFF_PINREF, 32'h0FFF_0000);
    rd_chk("ctrl2 reset", sarseq_pkg::OFF_CTRL2, 32'h0000_0000);
    axi_read(8'h18, rd, rsp);
    `CHK("unmapped read", sarseq_pkg::RESP_SLVERR, rsp)
    axi_write(8'h18, 32'hFFFF_FFFF, rsp);
    `CHK("unmapped write", sarseq_pkg::RESP_SLVERR, rsp)
    // start request while switched off
    wr(sarseq_pkg::OFF_CTRL0, 32'h0000_0002);
    repeat (60) @(posedge aclk);
    `CHK("off flag", 1'b0, conversion_complete_flag)
    `CHK("off sample", 1'b0, analog_ctrl.sample_en)
    // references and per-pin modes
    wr(sarseq_pkg::OFF_PINREF, 32'h00A5_0003);
    `CHK("vref pos", 1'b1, analog_ctrl.vref_pos_ext)
    `CHK("vref neg", 1'b1, analog_ctrl.vref_neg_ext)
    `CHK("pin modes", 12'h0A5, analog_pin_en)
    // every acquisition code, then every divided clock source
    for (int i = 0; i < 8; i++)
      convert(3'h0, i[2:0], 2, acq_n[i], 12'h3A5 + 12'(i * 397), i[3:0]);
    for (int i = 0; i < 6; i++)
      convert(clk_code[i], 3'h1, div_n[i], 2, 12'hFFF - 12'(i * 511), 4'(i + 5));
    // rc conversion clock carries on while asleep
    sleep_mode <= 1'b1;
    convert(3'h3, 3'h1, 4, 2, 12'h001, 4'hB);
    sleep_mode <= 1'b0;
    // reset during a slow conversion
    level <= 12'h777;
    wr(sarseq_pkg::OFF_CTRL2, 32'h0000_0006);
    wr(sarseq_pkg::OFF_CTRL0, 32'h0000_0003);
    repeat (100) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("reset off", 1'b0, analog_ctrl.module_on)
    repeat (900) @(posedge aclk);
    `CHK("reset flag", 1'b0, conversion_complete_flag)
    rd_chk("kept high", sarseq_pkg::OFF_RES_HI, {28'h0, last[11:8]});
    rd_chk("kept low", sarseq_pkg::OFF_RES_LO, {24'h0, last[7:0]});
    rd_chk("ctrl2 cleared", sarseq_pkg::OFF_CTRL2, 32'h0000_0000);
    results();
  end
endmodule : tb_sarseq_core
